/* File: rtl/gas_sensor_dev.sv */
// Sensor end: mode control, reading path, filter and zero-point calibration.
// Assumes raw_sample_i is a fresh raw concentration sample, synchronous to clk,
// and that nv_mode_i holds the persisted mode while rst_i is released.
// Functional notes
// - Sleep mode: no measurements, waits for commands
// - Sleep rejects reading and zero commands
// - Sleep mode is never persisted
// - Streaming default, twenty readings per second
// - Streaming defers commands during measurement, under 10ms
// - Polling measures silently, replies on request
// - Streaming or polling restored after power-up
// - Filtered and raw readings both available
// - Larger filter setting: less noise, slower
// - Host picks filter setting by flow rate
// - Host sets filter 32 before zeroing
// - Each zero fully replaces the previous; fine adjust here adds its correction to the old zero
// - Known-gas zero uses host-scaled concentration
// - Nitrogen zero assumes zero concentration
// - Fresh-air reference programmable, default 400
// - Fine adjust from true and reported values
// - Auto-zero off by default, reset on power
// - Auto-zero acts like fresh-air, own reference
// - Auto-zero periodic or forced immediately
// - Programmable initial and repeat auto-zero intervals
// - Fixed rate; faster requests return previous reading
// - Unknown command answered with unknown status
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "gas_ctl_defines.svh"
module gas_sensor_dev #(
	parameter int READ_CYC = `READ_PERIOD_CYC,
	parameter int BUSY_CYC = `DEFER_MAX_CYC
) (
	input  wire logic                  clk_sys_i,
	input  wire logic                  rst_i,
	gas_link_if.dev                    link,
	input  wire gas_ctl_pkg::reading_t raw_sample_i,
	input  wire logic [1:0]            nv_mode_i,
	output logic                       nv_wr_o,
	output logic [1:0]                 nv_mode_o,
	output logic                       sleep_o
);
	localparam int CW = $clog2(READ_CYC + 1);

	function automatic logic needs_active(input logic [7:0] op);
		case (op)
			gas_ctl_pkg::OP_READ, gas_ctl_pkg::OP_ZERO_KNOWN, gas_ctl_pkg::OP_ZERO_N2,
			gas_ctl_pkg::OP_ZERO_AIR, gas_ctl_pkg::OP_ZERO_FINE,
			gas_ctl_pkg::OP_AZ_FORCE: needs_active = 1'b1;
			default: needs_active = 1'b0;
		endcase
	endfunction

	function automatic logic known_op(input logic [7:0] op);
		case (op)
			gas_ctl_pkg::OP_SET_FILTER, gas_ctl_pkg::OP_GET_FILTER, gas_ctl_pkg::OP_SET_AIR,
			gas_ctl_pkg::OP_SET_AZ_REF, gas_ctl_pkg::OP_AZ_ENABLE, gas_ctl_pkg::OP_AZ_INIT,
			gas_ctl_pkg::OP_AZ_PERIOD, gas_ctl_pkg::OP_SET_MODE: known_op = 1'b1;
			default: known_op = needs_active(op);
		endcase
	endfunction

	function automatic logic [3:0] filt_shift(input logic [7:0] s);
		filt_shift = 4'h0;
		for (int i = 1; i < 8; i++) begin
			if (s >= (8'h01 << i))
				filt_shift = 4'(i);
		end
	endfunction

	gas_ctl_pkg::mode_e    mode_r;
	logic                  boot_r;
	logic [CW-1:0]         tick_cnt_r;
	logic [CW-1:0]         busy_cnt_r;
	gas_ctl_pkg::reading_t raw_r;
	gas_ctl_pkg::reading_t samp_r;
	gas_ctl_pkg::reading_t filt_r;
	gas_ctl_pkg::reading_t zero_r;
	logic [7:0]            filter_r;
	gas_ctl_pkg::reading_t air_ref_r;
	gas_ctl_pkg::reading_t az_ref_r;
	logic                  az_en_r;
	logic [23:0]           az_init_r;
	logic [23:0]           az_period_r;
	logic [23:0]           az_cnt_r;
	logic                  rsp_valid_r;
	logic [7:0]            rsp_op_r;
	gas_ctl_pkg::status_e  rsp_status_r;
	gas_ctl_pkg::reading_t rsp_val0_r;
	gas_ctl_pkg::reading_t rsp_val1_r;
	logic                  str_valid_r;
	logic                  nv_wr_r;
	logic [1:0]            nv_mode_r;

	wire logic                  sleeping   = (mode_r == gas_ctl_pkg::MODE_SLEEP);
	wire logic                  tick       = !sleeping && !boot_r && (tick_cnt_r == '0);
	wire logic                  defer      = (mode_r == gas_ctl_pkg::MODE_STREAM)
	                                         && (busy_cnt_r != '0);
	wire logic                  take       = link.cmd_valid && !defer && !rsp_valid_r
	                                         && !boot_r;
	wire logic [7:0]            op         = link.cmd_op;
	wire logic                  op_known   = known_op(op);
	wire logic                  mode_bad   = (op == gas_ctl_pkg::OP_SET_MODE)
	                                         && (link.cmd_arg0 > 16'h0002);
	wire logic                  refuse     = sleeping && needs_active(op);
	wire logic                  accept     = take && op_known && !mode_bad && !refuse;
	wire logic                  is_op_read = accept && (op == gas_ctl_pkg::OP_READ);
	wire logic signed [16:0]    corr_s     = $signed({1'b0, raw_sample_i})
	                                         - $signed({1'b0, zero_r});
	wire gas_ctl_pkg::reading_t corr       = corr_s[16] ? 16'h0000 : corr_s[15:0];
	wire logic signed [16:0]    fdiff      = $signed({1'b0, corr}) - $signed({1'b0, filt_r});
	wire logic signed [16:0]    fstep      = fdiff >>> filt_shift(filter_r);
	wire gas_ctl_pkg::reading_t filt_nxt   = 16'(filt_r + fstep[15:0]);
	wire logic                  az_due     = tick && az_en_r && (az_cnt_r == 24'h000001);
	wire logic                  az_fire    = az_due
	                                         || (accept && op == gas_ctl_pkg::OP_AZ_FORCE);

	// Zeros other than fine adjust are worked from the uncorrected sample; fine adjust builds on the old zero
	logic                  zero_we;
	logic                  zero_cmd;
	gas_ctl_pkg::reading_t zero_nxt;
	always_comb begin
		zero_cmd = accept;
		zero_nxt = zero_r;
		case (op)
			gas_ctl_pkg::OP_ZERO_KNOWN: zero_nxt = 16'(samp_r - link.cmd_arg0);
			gas_ctl_pkg::OP_ZERO_N2:    zero_nxt = samp_r;
			gas_ctl_pkg::OP_ZERO_AIR:   zero_nxt = 16'(samp_r - air_ref_r);
			gas_ctl_pkg::OP_ZERO_FINE:  zero_nxt = 16'(zero_r + link.cmd_arg1
			                                          - link.cmd_arg0);
			default:                    zero_cmd = 1'b0;
		endcase
		zero_we = zero_cmd;
		if (az_fire) begin
			zero_we  = 1'b1;
			zero_nxt = 16'(samp_r - az_ref_r);
		end
	end

	// Only zero commands report the new zero; a periodic zero must not leak into other replies
	wire logic zero_rsp = zero_cmd || (accept && op == gas_ctl_pkg::OP_AZ_FORCE);

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			mode_r <= gas_ctl_pkg::MODE_STREAM;
			boot_r <= 1'b1;
		end else if (boot_r) begin
			boot_r <= 1'b0;
			mode_r <= (nv_mode_i == gas_ctl_pkg::MODE_POLL) ? gas_ctl_pkg::MODE_POLL
			                                                : gas_ctl_pkg::MODE_STREAM;
		end else if (accept && op == gas_ctl_pkg::OP_SET_MODE) begin
			mode_r <= gas_ctl_pkg::mode_e'(link.cmd_arg0[1:0]);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			nv_wr_r   <= 1'b0;
			nv_mode_r <= 2'h1;
		end else begin
			nv_wr_r <= accept && op == gas_ctl_pkg::OP_SET_MODE
			           && link.cmd_arg0[1:0] != gas_ctl_pkg::MODE_SLEEP;
			if (accept && op == gas_ctl_pkg::OP_SET_MODE)
				nv_mode_r <= link.cmd_arg0[1:0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || sleeping || boot_r) begin
			tick_cnt_r <= '0;
			busy_cnt_r <= '0;
		end else begin
			tick_cnt_r <= (tick_cnt_r == CW'(READ_CYC - 1)) ? '0 : tick_cnt_r + 1'b1;
			busy_cnt_r <= tick ? CW'(BUSY_CYC) : (busy_cnt_r != '0) ? busy_cnt_r - 1'b1 : '0;
		end
	end

	// Measurement path keeps running in polling mode, stream is gated
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			raw_r       <= 16'h0000;
			samp_r      <= 16'h0000;
			filt_r      <= 16'h0000;
			str_valid_r <= 1'b0;
		end else begin
			str_valid_r <= tick && (mode_r == gas_ctl_pkg::MODE_STREAM);
			if (tick) begin
				samp_r <= raw_sample_i;
				raw_r  <= corr;
				filt_r <= filt_nxt;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			zero_r      <= 16'h0000;
			filter_r    <= `FILTER_RST;
			air_ref_r   <= `AIR_REF_RST;
			az_ref_r    <= `AZ_REF_RST;
			az_en_r     <= 1'b0;
			az_init_r   <= `AZ_INIT_RST;
			az_period_r <= `AZ_PERIOD_RST;
			az_cnt_r    <= 24'h000000;
		end else begin
			if (zero_we)
				zero_r <= zero_nxt;
			if (accept) begin
				case (op)
					gas_ctl_pkg::OP_SET_FILTER: filter_r    <= link.cmd_arg0[7:0];
					gas_ctl_pkg::OP_SET_AIR:    air_ref_r   <= link.cmd_arg0;
					gas_ctl_pkg::OP_SET_AZ_REF: az_ref_r    <= link.cmd_arg0;
					gas_ctl_pkg::OP_AZ_INIT:    az_init_r   <= {8'h00, link.cmd_arg0};
					gas_ctl_pkg::OP_AZ_PERIOD:  az_period_r <= {8'h00, link.cmd_arg0};
					default: ;
				endcase
			end
			if (accept && op == gas_ctl_pkg::OP_AZ_ENABLE) begin
				az_en_r  <= link.cmd_arg0[0];
				az_cnt_r <= az_init_r;
			end else if (az_due) begin
				az_cnt_r <= az_period_r;
			end else if (tick && az_en_r && az_cnt_r > 24'h000001) begin
				az_cnt_r <= az_cnt_r - 24'h000001;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rsp_valid_r  <= 1'b0;
			rsp_op_r     <= 8'h00;
			rsp_status_r <= gas_ctl_pkg::ST_OK;
			rsp_val0_r   <= 16'h0000;
			rsp_val1_r   <= 16'h0000;
		end else begin
			rsp_valid_r <= take;
			if (take) begin
				rsp_op_r     <= op;
				rsp_status_r <= (!op_known || mode_bad) ? gas_ctl_pkg::ST_UNKNOWN
				              : refuse ? gas_ctl_pkg::ST_REJECT : gas_ctl_pkg::ST_OK;
				rsp_val0_r   <= is_op_read ? filt_r : (op == gas_ctl_pkg::OP_GET_FILTER)
				                ? {8'h00, filter_r} : zero_rsp ? zero_nxt : link.cmd_arg0;
				rsp_val1_r   <= is_op_read ? raw_r : 16'h0000;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i)
			sleep_o <= 1'b0;
		else
			sleep_o <= sleeping;
	end

	assign link.rsp_valid  = rsp_valid_r;
	assign link.rsp_op     = rsp_op_r;
	assign link.rsp_status = rsp_status_r;
	assign link.rsp_val0   = rsp_val0_r;
	assign link.rsp_val1   = rsp_val1_r;
	assign link.str_valid  = str_valid_r;
	assign link.str_filt   = filt_r;
	assign link.str_raw    = raw_r;
	assign nv_wr_o         = nv_wr_r;
	assign nv_mode_o       = nv_mode_r;
endmodule // gas_sensor_dev
`default_nettype wire

/* File: inc/gas_ctl_defines.svh */
// Constants shared by both ends of the gas sensor control link.
// Assumes a 10 MHz system clock; counts follow from the nominal reading and deferral times.
`ifndef GAS_CTL_DEFINES_SVH
`define GAS_CTL_DEFINES_SVH

`define CLK_PERIOD_NS     100
`define READ_PERIOD_MS    50
`define READ_PERIOD_CYC   ((`READ_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define DEFER_MAX_MS      10
`define DEFER_MAX_CYC     ((`DEFER_MAX_MS * 1000000) / `CLK_PERIOD_NS)

`define AIR_REF_RST       16'h0190
`define AZ_REF_RST        16'h0190
`define FILTER_RST        8'h10
`define AZ_INIT_RST       24'h000000
`define AZ_PERIOD_RST     24'h000000

`define REG_CTRL          8'h00
`define REG_ARG           8'h04
`define REG_STATUS        8'h08
`define REG_RESULT        8'h0C
`define REG_STREAM        8'h10
`define REG_STREAM_CNT    8'h14
`define CTRL_GO_BIT       8

`endif

/* File: inc/gas_ctl_pkg.sv */
// Types shared by both ends of the gas sensor control link.
// Assumes nothing beyond a SystemVerilog compiler.
package gas_ctl_pkg;

	typedef enum logic [1:0] {
		MODE_SLEEP  = 2'h0,
		MODE_STREAM = 2'h1,
		MODE_POLL   = 2'h2
	} mode_e;

	typedef enum logic [7:0] {
		OP_SET_FILTER = 8'h01,
		OP_GET_FILTER = 8'h02,
		OP_READ       = 8'h03,
		OP_ZERO_KNOWN = 8'h10,
		OP_ZERO_N2    = 8'h11,
		OP_ZERO_AIR   = 8'h12,
		OP_ZERO_FINE  = 8'h13,
		OP_AZ_FORCE   = 8'h14,
		OP_SET_AIR    = 8'h20,
		OP_SET_AZ_REF = 8'h21,
		OP_AZ_ENABLE  = 8'h22,
		OP_AZ_INIT    = 8'h23,
		OP_AZ_PERIOD  = 8'h24,
		OP_SET_MODE   = 8'h30
	} op_e;

	typedef enum logic [1:0] {
		ST_OK      = 2'h0,
		ST_REJECT  = 2'h1,
		ST_UNKNOWN = 2'h2
	} status_e;

	typedef logic [15:0] reading_t;

endpackage

/* File: inc/gas_link_if.sv */
// Command, reply and stream link between host controller and sensor.
// Both ends share clk_sys_i; the testbench connects the two modports.
`timescale 1ns/100ps
`default_nettype none
interface gas_link_if;
	logic                       cmd_valid;
	logic [7:0]                 cmd_op;
	logic [15:0]                cmd_arg0;
	logic [15:0]                cmd_arg1;
	logic                       rsp_valid;
	logic [7:0]                 rsp_op;
	gas_ctl_pkg::status_e       rsp_status;
	gas_ctl_pkg::reading_t      rsp_val0;
	gas_ctl_pkg::reading_t      rsp_val1;
	logic                       str_valid;
	gas_ctl_pkg::reading_t      str_filt;
	gas_ctl_pkg::reading_t      str_raw;

	modport dev  (input cmd_valid, cmd_op, cmd_arg0, cmd_arg1,
		output rsp_valid, rsp_op, rsp_status, rsp_val0, rsp_val1,
		str_valid, str_filt, str_raw);
	modport host (output cmd_valid, cmd_op, cmd_arg0, cmd_arg1,
		input rsp_valid, rsp_op, rsp_status, rsp_val0, rsp_val1,
		str_valid, str_filt, str_raw);
endinterface // gas_link_if
`default_nettype wire

/* File: rtl/gas_host_ctl.sv */
// Host end: AHB-Lite register slave that issues link commands and keeps stream data.
// Assumes a single AHB-Lite master; the link's device end shares clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
`include "gas_ctl_defines.svh"
module gas_host_ctl (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	gas_link_if.host         link,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic [31:0]      hrdata_o
);
	typedef enum logic [0:0] {S_IDLE = 1'b0, S_WAIT = 1'b1} hst_e;

	hst_e                  st_r;
	logic                  wr_pend_r;
	logic [7:0]            wr_addr_r;
	logic [7:0]            op_r;
	logic [31:0]           arg_r;
	gas_ctl_pkg::status_e  status_r;
	logic [7:0]            rsp_op_r;
	logic [31:0]           result_r;
	logic [31:0]           stream_r;
	logic [15:0]           str_cnt_r;
	logic [31:0]           rdata_r;

	wire logic        phase_ok = hsel_i && hready_i && htrans_i[1];
	wire logic [7:0]  a_addr   = haddr_i[7:0];
	wire logic        go       = wr_pend_r && wr_addr_r == `REG_CTRL
	                             && hwdata_i[`CTRL_GO_BIT] && st_r == S_IDLE;
	wire logic [31:0] rd_mux   =
		(a_addr == `REG_CTRL)       ? {24'h000000, op_r} :
		(a_addr == `REG_ARG)        ? arg_r :
		(a_addr == `REG_STATUS)     ? {16'h0000, rsp_op_r, 5'h00, status_r, st_r} :
		(a_addr == `REG_RESULT)     ? result_r :
		(a_addr == `REG_STREAM)     ? stream_r :
		(a_addr == `REG_STREAM_CNT) ? {16'h0000, str_cnt_r} : 32'h00000000;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rdata_r   <= 32'h00000000;
		end else begin
			wr_pend_r <= phase_ok && hwrite_i;
			if (phase_ok)
				wr_addr_r <= a_addr;
			if (phase_ok && !hwrite_i)
				rdata_r <= rd_mux;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			op_r  <= 8'h00;
			arg_r <= 32'h00000000;
		end else if (wr_pend_r && st_r == S_IDLE) begin
			if (wr_addr_r == `REG_CTRL)
				op_r <= hwdata_i[7:0];
			if (wr_addr_r == `REG_ARG)
				arg_r <= hwdata_i;
		end
	end

	// Waits as long as the device takes; streaming may hold a reply up to 10ms
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			st_r     <= S_IDLE;
			status_r <= gas_ctl_pkg::ST_OK;
			rsp_op_r <= 8'h00;
			result_r <= 32'h00000000;
		end else if (st_r == S_IDLE) begin
			if (go)
				st_r <= S_WAIT;
		end else if (link.rsp_valid) begin
			st_r     <= S_IDLE;
			status_r <= link.rsp_status;
			rsp_op_r <= link.rsp_op;
			result_r <= {link.rsp_val1, link.rsp_val0};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			stream_r  <= 32'h00000000;
			str_cnt_r <= 16'h0000;
		end else if (link.str_valid) begin
			stream_r  <= {link.str_raw, link.str_filt};
			str_cnt_r <= str_cnt_r + 16'h0001;
		end
	end

	assign link.cmd_valid = (st_r == S_WAIT);
	assign link.cmd_op    = op_r;
	assign link.cmd_arg0  = arg_r[15:0];
	assign link.cmd_arg1  = arg_r[31:16];
	assign hreadyout_o    = 1'b1;
	assign hresp_o        = 1'b0;
	assign hrdata_o       = rdata_r;
endmodule // gas_host_ctl
`default_nettype wire

/* File: testbench/gas_link_asserts.sv */
// Checker on the link between host controller and sensor.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module gas_link_asserts #(
	parameter int READ_CYC = 40,
	parameter int BUSY_CYC = 8
) (
	input wire logic                  clk_sys_i,
	input wire logic                  rst_i,
	input wire logic                  cmd_valid,
	input wire logic [7:0]            cmd_op,
	input wire logic [15:0]           cmd_arg0,
	input wire logic                  rsp_valid,
	input wire logic [7:0]            rsp_op,
	input wire gas_ctl_pkg::status_e  rsp_status,
	input wire gas_ctl_pkg::reading_t rsp_val0,
	input wire logic                  str_valid
);
	localparam int ANS_MAX = BUSY_CYC + 1;
	int gap_r;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// Cycles since the last stream pulse, saturating at one period
	always_ff @(posedge clk_sys_i) begin
		if (rst_i)
			gap_r <= READ_CYC;
		else if (str_valid)
			gap_r <= 1;
		else if (gap_r < READ_CYC)
			gap_r <= gap_r + 1;
	end
	a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
		else $error("reply pulse longer than one cycle");
	a_rsp_has_cmd: assert property (rsp_valid |-> cmd_valid)
		else $error("reply without a pending command");
	a_cmd_release: assert property (rsp_valid |=> !cmd_valid)
		else $error("command not dropped after reply");
	a_cmd_hold: assert property ((cmd_valid && !rsp_valid) |=>
		cmd_valid && $stable(cmd_op) && $stable(cmd_arg0))
		else $error("command changed before reply");
	a_answer_bound: assert property ($rose(cmd_valid) |-> ##[1:ANS_MAX] rsp_valid)
		else $error("reply later than deferral limit");
	a_stream_rate: assert property (str_valid |-> gap_r >= READ_CYC)
		else $error("stream pulses closer than one period");
	a_op_echo: assert property (rsp_valid |-> rsp_op == cmd_op)
		else $error("reply opcode differs from command");
	a_unknown_op: assert property ((rsp_valid && !(cmd_op inside
		{[8'h01:8'h03], [8'h10:8'h14], [8'h20:8'h24], 8'h30}))
		|-> rsp_status == gas_ctl_pkg::ST_UNKNOWN)
		else $error("unknown opcode not flagged");
	a_bad_mode: assert property ((rsp_valid && cmd_op == 8'h30 && cmd_arg0 > 16'h0002)
		|-> rsp_status == gas_ctl_pkg::ST_UNKNOWN)
		else $error("illegal mode accepted");
	a_filter_echo: assert property ((rsp_valid && cmd_op == 8'h01 && cmd_arg0[15:8] == 8'h00)
		|-> rsp_status == gas_ctl_pkg::ST_OK && rsp_val0 == cmd_arg0)
		else $error("filter setting not echoed");
	a_rsp_hold: assert property (!rsp_valid |-> $stable(rsp_val0) && $stable(rsp_status))
		else $error("reply fields changed without reply");
endmodule // gas_link_asserts
`default_nettype wire

/* File: testbench/test_gas_sensor_mode_and_zero_control.sv */
// Bench joining host controller and sensor over the link, driven over AHB-Lite.
// Assumes a 10 MHz clock and shortened reading and deferral counts.
`timescale 1ns/100ps
`default_nettype none
`include "gas_ctl_defines.svh"
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("unexpected %s exp %0h got %0h", nm, exp, got); end end
module test_gas_sensor_mode_and_zero_control;
	localparam int RC = 40;
	localparam int BC = 8;
	logic        clk_sys_i, rst_i, hwrite, hrdy, hresp, nv_wr, sleep;
	logic [1:0]  htrans, nvm, nv_mode, nvl;
	logic [31:0] haddr, hwdata, hrdata, rd, st, res;
	logic [15:0] smp, d;
	int          n_fail, n_checks, cyc, nvw;
	gas_link_if link ();
	gas_sensor_dev #(.READ_CYC(RC), .BUSY_CYC(BC)) gas_sensor_dev_i (.clk_sys_i(clk_sys_i),
		.rst_i(rst_i), .link(link.dev), .raw_sample_i(smp), .nv_mode_i(nvm),
		.nv_wr_o(nv_wr), .nv_mode_o(nv_mode), .sleep_o(sleep));
	gas_host_ctl gas_host_ctl_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link.host),
		.hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
		.hresp_o(hresp), .hrdata_o(hrdata));
	gas_link_asserts #(.READ_CYC(RC), .BUSY_CYC(BC)) gas_link_asserts_i (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_valid(link.cmd_valid),
		.cmd_op(link.cmd_op), .cmd_arg0(link.cmd_arg0), .rsp_valid(link.rsp_valid),
		.rsp_op(link.rsp_op), .rsp_status(link.rsp_status), .rsp_val0(link.rsp_val0),
		.str_valid(link.str_valid));
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc++;
		if (nv_wr)
			nvw++;
		if (nv_wr)
			nvl <= nv_mode;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] r);
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		@(posedge clk_sys_i);
		while (hrdy !== 1'b1) @(posedge clk_sys_i);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk_sys_i);
		while (hrdy !== 1'b1) @(posedge clk_sys_i);
		r = hrdata;
	endtask
	// Issue one command, wait until not busy, fetch the result
	task automatic cmd(input logic [7:0] op, input logic [15:0] a0,
			input gas_ctl_pkg::status_e es = gas_ctl_pkg::ST_OK, input logic [15:0] a1 = 16'h0000);
		ahb(1'b1, `REG_ARG, {a1, a0}, rd);
		ahb(1'b1, `REG_CTRL, {23'h000000, 1'b1, op}, rd);
		do ahb(1'b0, `REG_STATUS, 32'h0, st); while (st[0] !== 1'b0);
		`CHK("reply op", op, st[15:8])
		`CHK("status", es, st[2:1])
		ahb(1'b0, `REG_RESULT, 32'h0, res);
	endtask
	// Command, then let n readings pass and compare the corrected raw reading
	task automatic zchk(input logic [7:0] op, input logic [15:0] a0, a1, ex, input int n);
		cmd(op, a0, gas_ctl_pkg::ST_OK, a1);
		repeat (n * RC + 4) @(posedge clk_sys_i);
		ahb(1'b0, `REG_STREAM, 32'h0, rd);
		`CHK("reading", ex, rd[31:16])
	endtask
	// Stream pulses seen across exactly four reading periods
	task automatic spulses(output logic [15:0] n);
		logic [31:0] c0;
		ahb(1'b0, `REG_STREAM_CNT, 32'h0, c0);
		repeat (4 * RC - 2) @(posedge clk_sys_i);
		ahb(1'b0, `REG_STREAM_CNT, 32'h0, rd);
		n = rd[15:0] - c0[15:0];
	endtask
	task automatic reset_dev();
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
	endtask
	initial begin
		n_fail = 0;
		n_checks = 0;
		cyc = 0;
		nvw = 0;
		nvl = 2'h0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		smp = 16'h0400;
		nvm = 2'h1;
		reset_dev();
		cmd(8'h02, 16'h0);
		`CHK("filter", 16'h0010, res[15:0])
		cmd(8'h01, 16'h0);
		spulses(d);
		`CHK("stream pulses", 16'h0004, d)
		ahb(1'b0, `REG_STREAM, 32'h0, rd);
		`CHK("stream", 32'h04000400, rd)
		cmd(8'h03, 16'h0);
		`CHK("read", 32'h04000400, res)
		cmd(8'h7F, 16'h0, gas_ctl_pkg::ST_UNKNOWN);
		$display("test defaults done");
		cmd(8'h01, 16'h0020);
		zchk(8'h10, 16'h0190, 16'h0, 16'h0190, 1);
		`CHK("filter lag", 1'b1, rd[15:0] > rd[31:16])
		zchk(8'h11, 16'h0, 16'h0, 16'h0000, 1);
		zchk(8'h12, 16'h0, 16'h0, 16'h0190, 1);
		cmd(8'h20, 16'h0100);
		zchk(8'h12, 16'h0, 16'h0, 16'h0100, 1);
		zchk(8'h13, 16'h01F4, 16'h0100, 16'h01F4, 1);
		cmd(8'h21, 16'h012C);
		zchk(8'h14, 16'h0, 16'h0, 16'h012C, 1);
		smp <= 16'h0500;
		zchk(8'h02, 16'h0, 16'h0, 16'h022C, 3);
		cmd(8'h23, 16'h0002);
		cmd(8'h24, 16'h0002);
		zchk(8'h22, 16'h0001, 16'h0, 16'h012C, 3);
		smp <= 16'h0600;
		zchk(8'h02, 16'h0, 16'h0, 16'h012C, 4);
		cmd(8'h22, 16'h0000);
		cmd(8'h01, 16'h0000);
		$display("test zero point done");
		cmd(8'h30, 16'h0000);
		`CHK("sleep", 1'b1, sleep)
		cmd(8'h03, 16'h0, gas_ctl_pkg::ST_REJECT);
		cmd(8'h11, 16'h0, gas_ctl_pkg::ST_REJECT);
		cmd(8'h14, 16'h0, gas_ctl_pkg::ST_REJECT);
		spulses(d);
		`CHK("sleep pulses", 16'h0000, d)
		`CHK("nv writes", 0, nvw)
		cmd(8'h30, 16'h0003, gas_ctl_pkg::ST_UNKNOWN);
		cmd(8'h30, 16'h0002);
		`CHK("nv mode", 2'h2, nvl)
		`CHK("sleep", 1'b0, sleep)
		spulses(d);
		`CHK("poll pulses", 16'h0000, d)
		cmd(8'h03, 16'h0);
		`CHK("poll read", 32'h012C012C, res)
		cmd(8'h30, 16'h0001);
		spulses(d);
		`CHK("stream pulses", 16'h0004, d)
		$display("test modes done");
		nvm <= 2'h2;
		reset_dev();
		spulses(d);
		`CHK("restored poll", 16'h0000, d)
		`CHK("restored poll count", 16'h0000, rd[15:0])
		nvm <= 2'h0;
		reset_dev();
		spulses(d);
		`CHK("no sleep at power", 16'h0004, d)
		$display("test power cycle done");
		wrap_up();
	end
endmodule // test_gas_sensor_mode_and_zero_control
`default_nettype wire
